// ---- core/bhsp_regs.svh ----
`ifndef BHSP_REGS_SVH
`define BHSP_REGS_SVH

// Host space geometry: 64 quadlet registers seen as 256 bytes.
`define BHSP_NUM_QUADLETS 64
`define BHSP_BYTE_SPACE 256
// Quadlet index of the request and response receive queue ports.
`define BHSP_RX_REQUEST_QUEUE_PORT 6'h30
`define BHSP_RX_RESPONSE_QUEUE_PORT 6'h31
// Depth of each receive queue buffer in quadlets.
`define BHSP_QUEUE_DEPTH 32
// Reset values of the shadows and the byte bus.
`define BHSP_SHADOW_RESET 32'h0000_0000
`define BHSP_BYTE_RESET 8'h00

`endif

// ---- core/bhsp_pkg.sv ----
package bhsp_pkg;

   // Host address as nine pins: update line, quadlet index, byte lane.
   typedef struct packed {
      logic shadow_update;
      logic [5:0] quadlet_index;
      logic [1:0] byte_lane;
   } bhsp_addr_t;

   // One receive queue entry: end-of-packet mark and the quadlet.
   typedef struct packed {
      logic last;
      logic [31:0] data;
   } bhsp_qent_t;

   // Internal register access request.
   typedef struct packed {
      logic strobe;
      logic [5:0] index;
      logic [31:0] data;
   } bhsp_regreq_t;

endpackage

// ---- core/bhsp_port.sv ----
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
// Receive queue buffer with registered ready and empty.
module bhsp_fifo #(
   parameter int W = 33,
   parameter int DEPTH = 32
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [W-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [W-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] mem_r [DEPTH];
   logic [AW-1:0] wp_r;
   logic [AW-1:0] rp_r;
   logic [AW:0] cnt_r;
   logic [AW:0] cnt_nxt;
   logic space_r;
   logic empty_r;
   logic push;
   logic pop;

   // Ready is a flop of its own, low in reset, so the source never sees a gated ready.
   assign push = in_valid & space_r;
   assign pop = out_ready & ~empty_r;
   assign in_ready = space_r;
   assign out_valid = ~empty_r;
   assign out_data = mem_r[rp_r];

   // Occupancy moves by one at most; push and pop together cancel.
   always_comb
   begin
      cnt_nxt = cnt_r;
      if (push && !pop)
         cnt_nxt = cnt_r + (AW+1)'(1);
      else if (pop && !push)
         cnt_nxt = cnt_r - (AW+1)'(1);
   end

   // Pointers and flags.
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
         space_r <= 1'b0;
         empty_r <= 1'b1;
      end
      else
      begin
         if (push)
            wp_r <= (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + AW'(1);
         if (pop)
            rp_r <= (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + AW'(1);
         cnt_r <= cnt_nxt;
         space_r <= (cnt_nxt != (AW+1)'(DEPTH));
         empty_r <= (cnt_nxt == '0);
      end
   end

   // Storage has no reset; only written words are ever read.
   always_ff @(posedge clk)
   begin
      if (push)
         mem_r[wp_r] <= in_data;
   end
endmodule

////////////////////////////////////////////////////////////////////////////////
// Byte host port with read and write shadows and two receive queues.
`include "bhsp_regs.svh"
module bhsp_port #(
   parameter int DEPTH = `BHSP_QUEUE_DEPTH
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic host_select_n,
   input wire logic host_read_strobe_n,
   input wire logic host_write_strobe_n,
   input wire bhsp_pkg::bhsp_addr_t host_addr,
   input wire logic [7:0] host_byte_bus_in,
   output logic [7:0] host_byte_bus_out,
   output logic host_byte_bus_oe,
   output logic host_irq_n_out,
   output logic host_irq_n_oe,
   input wire logic irq_request,
   output bhsp_pkg::bhsp_regreq_t reg_rd,
   input wire logic [31:0] reg_rd_data,
   output bhsp_pkg::bhsp_regreq_t reg_wr,
   input wire bhsp_pkg::bhsp_qent_t rx_request_in,
   input wire logic rx_request_valid,
   output logic rx_request_ready,
   input wire bhsp_pkg::bhsp_qent_t rx_response_in,
   input wire logic rx_response_valid,
   output logic rx_response_ready,
   output logic rx_request_avail,
   output logic rx_response_avail,
   output logic rx_request_last,
   output logic rx_response_last,
   output logic rx_request_err,
   output logic rx_response_err
);
   import bhsp_pkg::*;

   logic [2:0] ctl_s1_r;
   logic [2:0] ctl_s2_r;
   bhsp_addr_t addr_s1_r;
   bhsp_addr_t addr_s2_r;
   logic [7:0] din_s1_r;
   logic [7:0] din_s2_r;
   logic rd_d_r;
   logic wr_d_r;
   logic rd_lvl;
   logic wr_lvl;
   logic rd_start;
   logic wr_start;
   logic [31:0] rshadow_r;
   logic [31:0] wshadow_r;
   logic [31:0] wshadow_nxt;
   bhsp_qent_t xfer_r [2];
   logic [1:0] xfer_valid_r;
   logic [1:0] fifo_valid;
   logic [1:0] fifo_take;
   logic [1:0] pop;
   logic [1:0] pop_try;
   bhsp_qent_t fifo_data [2];
   logic [1:0] last_r;
   logic [1:0] err_r;
   logic [7:0] byte_sel;

   ////////////////////////////////////////////////////////////////////////////
   // Strobes, address and data pass two flops; order is select, read, write.
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         ctl_s1_r <= 3'h7;
         ctl_s2_r <= 3'h7;
         addr_s1_r <= '0;
         addr_s2_r <= '0;
         din_s1_r <= `BHSP_BYTE_RESET;
         din_s2_r <= `BHSP_BYTE_RESET;
      end
      else
      begin
         ctl_s1_r <= {host_select_n, host_read_strobe_n, host_write_strobe_n};
         ctl_s2_r <= ctl_s1_r;
         addr_s1_r <= host_addr;
         addr_s2_r <= addr_s1_r;
         din_s1_r <= host_byte_bus_in;
         din_s2_r <= din_s1_r;
      end
   end

   // Access level is select and strobe both low; whichever falls last starts it.
   assign rd_lvl = ~ctl_s2_r[2] & ~ctl_s2_r[1];
   assign wr_lvl = ~ctl_s2_r[2] & ~ctl_s2_r[0];
   assign rd_start = rd_lvl & ~rd_d_r;
   assign wr_start = wr_lvl & ~wr_d_r;

   // Edge memory so a long read acts only once.
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         rd_d_r <= 1'b0;
         wr_d_r <= 1'b0;
      end
      else
      begin
         rd_d_r <= rd_lvl;
         wr_d_r <= wr_lvl;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Update read at a queue port tries a pop; elsewhere it snapshots a register.
   assign pop_try[0] = rd_start & addr_s2_r.shadow_update
      & (addr_s2_r.quadlet_index == `BHSP_RX_REQUEST_QUEUE_PORT);
   assign pop_try[1] = rd_start & addr_s2_r.shadow_update
      & (addr_s2_r.quadlet_index == `BHSP_RX_RESPONSE_QUEUE_PORT);
   assign pop = pop_try & xfer_valid_r;

   // Internal read request; the register space answers in the same cycle.
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         reg_rd <= '0;
      else
      begin
         reg_rd.strobe <= rd_start & addr_s2_r.shadow_update & ~|pop_try;
         reg_rd.index <= addr_s2_r.quadlet_index;
         reg_rd.data <= `BHSP_SHADOW_RESET;
      end
   end

   // Read shadow changes only on a snapshot or a pop, never on plain reads.
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         rshadow_r <= `BHSP_SHADOW_RESET;
      else if (reg_rd.strobe)
         rshadow_r <= reg_rd_data;
      else if (pop[0])
         rshadow_r <= xfer_r[0].data;
      else if (pop[1])
         rshadow_r <= xfer_r[1].data;
   end

   // Lane 0 is the most significant byte.
   always_comb
   begin
      case (addr_s2_r.byte_lane)
         2'h0: byte_sel = rshadow_r[31:24];
         2'h1: byte_sel = rshadow_r[23:16];
         2'h2: byte_sel = rshadow_r[15:8];
         2'h3: byte_sel = rshadow_r[7:0];
         default: byte_sel = `BHSP_BYTE_RESET;
      endcase
   end

   // Byte mux follows the lane lines during a held read; no new access needed.
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         host_byte_bus_out <= `BHSP_BYTE_RESET;
         host_byte_bus_oe <= 1'b0;
      end
      else
      begin
         host_byte_bus_out <= byte_sel;
         host_byte_bus_oe <= rd_lvl;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Write shadow: one lane per write; other lanes keep their last value.
   always_comb
   begin
      wshadow_nxt = wshadow_r;
      case (addr_s2_r.byte_lane)
         2'h0: wshadow_nxt[31:24] = din_s2_r;
         2'h1: wshadow_nxt[23:16] = din_s2_r;
         2'h2: wshadow_nxt[15:8] = din_s2_r;
         2'h3: wshadow_nxt[7:0] = din_s2_r;
         default: wshadow_nxt = wshadow_r;
      endcase
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         wshadow_r <= `BHSP_SHADOW_RESET;
      else if (wr_start)
         wshadow_r <= wshadow_nxt;
   end

   // Commit is one strobe carrying the whole merged quadlet.
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         reg_wr <= '0;
      else
      begin
         reg_wr.strobe <= wr_start & addr_s2_r.shadow_update;
         reg_wr.index <= addr_s2_r.quadlet_index;
         reg_wr.data <= wshadow_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Two queues: buffer, then a transfer register refilled without host help.
   bhsp_fifo #(.W(33), .DEPTH(DEPTH)) u_req_q (
      .clk(clk),
      .rstn(rstn),
      .in_data(rx_request_in),
      .in_valid(rx_request_valid),
      .in_ready(rx_request_ready),
      .out_data(fifo_data[0]),
      .out_valid(fifo_valid[0]),
      .out_ready(fifo_take[0])
   );

   bhsp_fifo #(.W(33), .DEPTH(DEPTH)) u_rsp_q (
      .clk(clk),
      .rstn(rstn),
      .in_data(rx_response_in),
      .in_valid(rx_response_valid),
      .in_ready(rx_response_ready),
      .out_data(fifo_data[1]),
      .out_valid(fifo_valid[1]),
      .out_ready(fifo_take[1])
   );

   // A transfer register takes a new head when empty or being popped now.
   assign fifo_take = ~xfer_valid_r | pop;

   // Transfer registers, last flags and error pulses per queue.
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         xfer_valid_r <= 2'h0;
         xfer_r[0] <= '0;
         xfer_r[1] <= '0;
         last_r <= 2'h0;
         err_r <= 2'h0;
      end
      else
      begin
         for (int q = 0; q < 2; q++)
         begin
            if (fifo_take[q] && fifo_valid[q])
            begin
               xfer_r[q] <= fifo_data[q];
               xfer_valid_r[q] <= 1'b1;
            end
            else if (pop[q])
               xfer_valid_r[q] <= 1'b0;
            if (pop[q])
               last_r[q] <= xfer_r[q].last;
            err_r[q] <= pop_try[q] & ~xfer_valid_r[q];
         end
      end
   end

   // Status outputs straight from the flops above.
   assign rx_request_avail = xfer_valid_r[0];
   assign rx_response_avail = xfer_valid_r[1];
   assign rx_request_last = last_r[0];
   assign rx_response_last = last_r[1];
   assign rx_request_err = err_r[0];
   assign rx_response_err = err_r[1];

   // Open-drain interrupt: pull low while the core requests it.
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         host_irq_n_out <= 1'b0;
         host_irq_n_oe <= 1'b0;
      end
      else
      begin
         host_irq_n_out <= 1'b0;
         host_irq_n_oe <= irq_request;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks next to the logic they guard.
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   a_oe_follows_read: assert property (rd_lvl |=> host_byte_bus_oe)
      else $error("data bus not driven during read");
   a_oe_idle_off: assert property (!rd_lvl |=> !host_byte_bus_oe)
      else $error("data bus driven outside read");
   a_one_snapshot: assert property (reg_rd.strobe |=> !reg_rd.strobe)
      else $error("more than one snapshot per access");
   a_snap_capture: assert property (reg_rd.strobe |=> rshadow_r == $past(reg_rd_data))
      else $error("snapshot not captured");
   a_shadow_holds: assert property ((rd_start && !addr_s2_r.shadow_update)
      |=> ##1 $stable(rshadow_r))
      else $error("plain read disturbed read shadow");
   a_commit_once: assert property ((wr_start && addr_s2_r.shadow_update)
      |=> reg_wr.strobe && reg_wr.data == $past(wshadow_nxt))
      else $error("commit missing or wrong");
   a_lane0_keep: assert property ((wr_start && addr_s2_r.byte_lane == 2'h0)
      |=> wshadow_r[23:0] == $past(wshadow_r[23:0]))
      else $error("unwritten lanes changed");
   a_lane0_msb: assert property ((addr_s2_r.byte_lane == 2'h0)
      |=> host_byte_bus_out == $past(rshadow_r[31:24]))
      else $error("lane 0 not most significant byte");
   a_pop_error: assert property ((pop_try[0] && !xfer_valid_r[0]) |=> rx_request_err)
      else $error("empty queue read not flagged");
   a_last_flag: assert property (pop[1] |=> rx_response_last == $past(xfer_r[1].last))
      else $error("last flag wrong after pop");
   a_refill: assert property ((!xfer_valid_r[0] && fifo_valid[0]) |=> xfer_valid_r[0])
      else $error("transfer register not refilled");

   c_snapshot: cover property (reg_rd.strobe);
   c_commit: cover property (reg_wr.strobe);
   c_pop_last: cover property (pop[0] ##1 rx_request_last);
   c_queue_full: cover property (!rx_request_ready);
endmodule

// ---- sim/bhsp_host_model.sv ----
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
// Byte-wide host processor: strobes, address and write data, plus read sampling.
module bhsp_host_model (
   input wire logic clk,
   output logic select_n,
   output logic read_n,
   output logic write_n,
   output bhsp_pkg::bhsp_addr_t addr,
   output logic [7:0] dout,
   output logic drv,
   input wire logic [7:0] bus,
   output logic [7:0] rd_byte,
   output logic rd_done
);
   import bhsp_pkg::*;

   // Idle bus with strobes high from time zero, so reset sees no access.
   initial
   begin
      select_n = 1'b1;
      read_n = 1'b1;
      write_n = 1'b1;
      addr = '0;
      dout = 8'h00;
      drv = 1'b0;
      rd_byte = 8'h00;
      rd_done = 1'b0;
   end

   // One extended read that sweeps n lanes; the lane output lags, so each byte waits.
   task automatic rd(input bhsp_addr_t a, input int n);
      begin
         addr <= a;
         repeat (3) @(posedge clk);
         select_n <= 1'b0;
         read_n <= 1'b0;
         for (int i = 0; i < n; i++)
         begin
            repeat (i == 0 ? 10 : 6) @(posedge clk);
            rd_byte <= bus;
            rd_done <= 1'b1;
            @(posedge clk);
            rd_done <= 1'b0;
            addr.byte_lane <= addr.byte_lane + 2'h1;
         end
         read_n <= 1'b1;
         select_n <= 1'b1;
         repeat (5) @(posedge clk);
      end
   endtask

   // One write byte; data and address are held well past the strobe rise.
   task automatic wr(input bhsp_addr_t a, input logic [7:0] d);
      begin
         addr <= a;
         dout <= d;
         drv <= 1'b1;
         repeat (3) @(posedge clk);
         select_n <= 1'b0;
         write_n <= 1'b0;
         repeat (6) @(posedge clk);
         write_n <= 1'b1;
         select_n <= 1'b1;
         repeat (4) @(posedge clk);
         drv <= 1'b0;
         @(posedge clk);
      end
   endtask
endmodule

// ---- sim/bhsp_port_tb.sv ----
`timescale 1ns/10ps
`include "bhsp_regs.svh"

////////////////////////////////////////////////////////////////////////////////
// Self-checking bench: bench holds the register file and the queue sources.
module bhsp_port_tb_top;
   import bhsp_pkg::*;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic sel_n, rd_n, wr_n, drv, rd_done, oe, irq_out, irq_oe;
   logic irq_req = 1'b0;
   logic [7:0] dout, bus, dut_out, rd_byte;
   logic [7:0] bus_last = 8'h00;
   bhsp_addr_t addr;
   bhsp_regreq_t reg_rd, reg_wr;
   bhsp_qent_t rx_in [2];
   logic rx_v [2];
   logic rx_rdy [2], av [2], lastf [2], err [2];
   logic [31:0] regs [64];
   logic [31:0] mdl [64];
   logic [31:0] wsh = 32'h0000_0000;
   logic [31:0] rsh = 32'h0000_0000;
   logic lst [2] = '{1'b0, 1'b0};
   logic [37:0] exp_wr [$];
   logic [7:0] exp_rd [$];
   bhsp_qent_t mq [2][$];
   int miscompares = 0;
   int checks = 0;
   int errs = 0;
   int errs_exp = 0;
   wire irq_wire = irq_oe ? irq_out : 1'b1;

   always #12.5 clk = ~clk;

   // Released data lines show the complement of the last driven value, never a stale value.
   assign bus = oe ? dut_out : (drv ? dout : ~bus_last);
   // Only driven values are remembered, so the idle pattern never turns unknown.
   always @(posedge clk)
      if (oe === 1'b1 || drv === 1'b1)
         bus_last <= bus;

   bhsp_host_model host (.clk(clk), .select_n(sel_n), .read_n(rd_n), .write_n(wr_n),
      .addr(addr), .dout(dout), .drv(drv), .bus(bus), .rd_byte(rd_byte),
      .rd_done(rd_done));

   bhsp_port #(.DEPTH(32)) dut (.clk(clk), .rstn(rstn), .host_select_n(sel_n),
      .host_read_strobe_n(rd_n), .host_write_strobe_n(wr_n), .host_addr(addr),
      .host_byte_bus_in(bus), .host_byte_bus_out(dut_out), .host_byte_bus_oe(oe),
      .host_irq_n_out(irq_out), .host_irq_n_oe(irq_oe), .irq_request(irq_req),
      .reg_rd(reg_rd), .reg_rd_data(regs[reg_rd.index]), .reg_wr(reg_wr),
      .rx_request_in(rx_in[0]), .rx_request_valid(rx_v[0]),
      .rx_request_ready(rx_rdy[0]), .rx_response_in(rx_in[1]),
      .rx_response_valid(rx_v[1]), .rx_response_ready(rx_rdy[1]),
      .rx_request_avail(av[0]), .rx_response_avail(av[1]), .rx_request_last(lastf[0]),
      .rx_response_last(lastf[1]), .rx_request_err(err[0]), .rx_response_err(err[1]));

   task automatic note(input logic [37:0] e, input logic [37:0] g);
      begin
         checks++;
         if (g !== e)
         begin
            miscompares++;
            $display("unexpected at %0t: expected %0h got %0h", $time, e, g);
         end
      end
   endtask
   task automatic chk_wr(input logic [37:0] e, input logic [37:0] g);
      note(e, g);
   endtask
   task automatic chk_byte(input logic [7:0] e, input logic [7:0] g);
      note({30'h0, e}, {30'h0, g});
   endtask
   task automatic chk_bit(input logic e, input logic g);
      note({37'h0, e}, {37'h0, g});
   endtask

   // Register file behind the port, and the watcher that retires each note.
   always @(posedge clk)
   begin
      if (reg_wr.strobe === 1'b1)
      begin
         regs[reg_wr.index] <= reg_wr.data;
         chk_wr(exp_wr.pop_front(), {reg_wr.index, reg_wr.data});
      end
      if (rd_done === 1'b1)
         chk_byte(exp_rd.pop_front(), rd_byte);
      if (err[0] === 1'b1 || err[1] === 1'b1)
         errs++;
   end

   // Shadow model: a refused pop leaves the read shadow as it was.
   task automatic rd_exp(input bhsp_addr_t a, input int n);
      int q;
      begin
         q = a.quadlet_index - `BHSP_RX_REQUEST_QUEUE_PORT;
         if (a.shadow_update && (q == 0 || q == 1))
         begin
            if (mq[q].size() == 0)
               errs_exp++;
            else
            begin
               lst[q] = mq[q][0].last;
               rsh = mq[q].pop_front().data;
            end
         end
         else if (a.shadow_update)
            rsh = mdl[a.quadlet_index];
         for (int i = 0; i < n; i++)
            exp_rd.push_back(8'(rsh >> (8 * (3 - (a.byte_lane + i) % 4))));
         host.rd(a, n);
      end
   endtask

   task automatic wr_exp(input bhsp_addr_t a, input logic [7:0] d);
      begin
         wsh[8 * (3 - a.byte_lane) +: 8] = d;
         if (a.shadow_update)
         begin
            mdl[a.quadlet_index] = wsh;
            exp_wr.push_back({a.quadlet_index, wsh});
         end
         host.wr(a, d);
      end
   endtask

   // Offer one entry and hold it until the queue takes it.
   task automatic push(input int q, input bhsp_qent_t e);
      begin
         rx_in[q] <= e;
         rx_v[q] <= 1'b1;
         mq[q].push_back(e);
         @(posedge clk);
         while (rx_rdy[q] !== 1'b1)
            @(posedge clk);
         rx_v[q] <= 1'b0;
         @(posedge clk);
      end
   endtask

   task automatic test_done;
      begin
         $display("checks %0d miscompares %0d", checks, miscompares);
         if (miscompares == 0 && checks > 0)
            $display("Run complete: PASS");
         else
            $display("Run complete: FAIL");
         $finish;
      end
   endtask

   // A hung handshake must not stall the run forever.
   initial
   begin
      repeat (20000) @(posedge clk);
      miscompares++;
      test_done;
   end

   // Main sequence.
   initial
   begin
      rx_v = '{1'b0, 1'b0};
      rx_in = '{33'h0, 33'h0};
      void'($urandom(83672));
      for (int i = 0; i < 64; i++)
         regs[i] = $urandom;
      mdl = regs;
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      repeat (5) @(posedge clk);
      chk_bit(1'b0, av[0]);
      chk_bit(1'b0, av[1]);
      chk_bit(1'b1, rx_rdy[1]);
      // Lanes out of order, then a lone lane keeps the rest.
      wr_exp({1'b0, 6'h05, 2'h3}, 8'($urandom));
      wr_exp({1'b0, 6'h05, 2'h1}, 8'($urandom));
      wr_exp({1'b0, 6'h05, 2'h0}, 8'($urandom));
      wr_exp({1'b1, 6'h05, 2'h2}, 8'($urandom));
      wr_exp({1'b1, 6'h05, 2'h1}, 8'($urandom));
      rd_exp({1'b1, 6'h05, 2'h0}, 4);
      wr_exp({1'b1, 6'h05, 2'h0}, 8'($urandom));
      rd_exp({1'b0, 6'h05, 2'h2}, 3);
      rd_exp({1'b1, 6'h05, 2'h2}, 1);
      // Every plain register location.
      for (int i = 0; i < 64; i++)
         if (i != `BHSP_RX_REQUEST_QUEUE_PORT && i != `BHSP_RX_RESPONSE_QUEUE_PORT)
         begin
            wr_exp({1'b1, 6'(i), 2'($urandom)}, 8'($urandom));
            rd_exp({1'b1, 6'(i), 2'($urandom)}, 4);
         end
      // Fill the request queue until it refuses, then drain it and pop once more.
      for (int i = 0; i < 33; i++)
         push(0, {i % 4 == 3, 32'($urandom)});
      repeat (3) @(posedge clk);
      chk_bit(1'b0, rx_rdy[0]);
      chk_bit(1'b1, av[0]);
      for (int i = 0; i < 34; i++)
      begin
         rd_exp({1'b1, 6'(`BHSP_RX_REQUEST_QUEUE_PORT), 2'h0}, 4);
         chk_bit(lst[0], lastf[0]);
      end
      chk_bit(1'b0, av[0]);
      for (int i = 0; i < 3; i++)
         push(1, {i == 2, 32'($urandom)});
      chk_bit(1'b1, av[1]);
      for (int i = 0; i < 4; i++)
      begin
         rd_exp({1'b1, 6'(`BHSP_RX_RESPONSE_QUEUE_PORT), 2'h0}, 4);
         chk_bit(lst[1], lastf[1]);
      end
      chk_bit(1'b0, av[1]);
      chk_byte(8'(errs_exp), 8'(errs));
      // Open-drain interrupt line follows the internal request.
      irq_req <= 1'b1;
      repeat (3) @(posedge clk);
      chk_bit(1'b0, irq_wire);
      irq_req <= 1'b0;
      repeat (3) @(posedge clk);
      chk_bit(1'b1, irq_wire);
      repeat (5) @(posedge clk);
      chk_byte(8'h00, 8'(exp_rd.size() + exp_wr.size()));
      test_done;
   end
endmodule
